//--- pin_route_pkg.sv
// Constants shared by the peripheral pin routing block.
`default_nettype none
package pin_route_pkg;
  // Bus geometry: byte address width, register index is address / 4.
  localparam int         ADDR_W       = 8;
  localparam int         IDX_W        = ADDR_W - 2;
  // Register indices (byte address is four times the index).
  localparam logic [5:0] IDX_TWO_WIRE = 6'h05;
  localparam logic [5:0] IDX_TIMER_A  = 6'h06;
  localparam logic [5:0] IDX_TIMER_B  = 6'h07;
  localparam logic [5:0] IDX_TIMER_D  = 6'h08;
  localparam logic [5:0] IDX_COMP     = 6'h09;
  localparam logic [5:0] IDX_ZERO_X   = 6'h0A;
  // Field widths and positions.
  localparam int         TWI_W        = 2;
  localparam int         TA_W         = 3;
  localparam int         TA0_LSB      = 0;
  localparam int         TA1_LSB      = 3;
  localparam int         TB_W         = 5;
  localparam int         TD_W         = 3;
  localparam int         CMP_W        = 3;
  localparam int         ZC_W         = 3;
  // Reset values of every routing register.
  localparam logic [7:0] RST_ROUTE    = 8'h00;
  // Field encodings.
  localparam logic [1:0] TWI_ALT_TWO  = 2'h2;
  localparam logic [1:0] TWI_RSVD     = 2'h3;
  localparam logic [2:0] TA0_RSVD     = 3'h7;
  localparam logic [2:0] TA1_PORT_G   = 3'h3;
  localparam logic [2:0] TD_ALT_THREE = 3'h3;
  // Port numbering and pin space.
  localparam int         PORT_A       = 0;
  localparam int         PORT_B       = 1;
  localparam int         PORT_C       = 2;
  localparam int         PORT_D       = 3;
  localparam int         PORT_E       = 4;
  localparam int         PORT_F       = 5;
  localparam int         PORT_G       = 6;
  localparam int         PINS_PER     = 8;
  localparam int         NUM_PINS     = 56;
  // Default and alternate pins of the single-output timers 0..4.
  localparam int TB_DEF_PIN [TB_W] = '{2, 3, 16, 13, 51};
  localparam int TB_ALT_PIN [TB_W] = '{44, 45, 12, 17, 22};

  // Flat pin index of pin n on port p.
  function automatic int pin_idx(input int p, input int n);
    return p * PINS_PER + n;
  endfunction : pin_idx
endpackage : pin_route_pkg
`default_nettype wire

//--- sync_2ff.sv
// Two-flop synchroniser for a vector of asynchronous pin levels.
`default_nettype none
module sync_2ff #(
  parameter int W = 8
) (
  // Clock and reset.
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Asynchronous levels in, synchronised levels out.
  input  wire logic [W-1:0] d,
  output logic      [W-1:0] q
);
  logic [W-1:0] meta_r; // First stage, read only by the second stage.

  // Two stages of flops; nothing else looks at the first one.
  // Both stages reset high, the pull-up idle level of the pins, so that a
  // routed input does not see a false falling edge just after reset.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      meta_r <= '1;
      q      <= '1;
    end
    else
    begin
      meta_r <= d;
      q      <= meta_r;
    end
  end
endmodule : sync_2ff
`default_nettype wire

//--- peripheral_pin_routing.sv
// Peripheral pin routing: AHB-Lite registers steering signals onto pins.
`default_nettype none
module peripheral_pin_routing (
  // Clock and reset.
  input  wire logic                              clk,
  input  wire logic                              rst_n,
  // AHB-Lite slave.
  input  wire logic                              hsel,
  input  wire logic [pin_route_pkg::ADDR_W-1:0]  haddr,
  input  wire logic [1:0]                        htrans,
  input  wire logic                              hwrite,
  input  wire logic [2:0]                        hsize,
  input  wire logic [31:0]                       hwdata,
  input  wire logic                              hready,
  output logic      [31:0]                       hrdata,
  output logic                                   hreadyout,
  output logic                                   hresp,
  // Two-wire interface 0, host/client side.
  input  wire logic                              host_sda_out,
  input  wire logic                              host_sda_oe,
  input  wire logic                              host_scl_out,
  input  wire logic                              host_scl_oe,
  output logic                                   host_sda_in,
  output logic                                   host_scl_in,
  // Two-wire interface 0, dual-mode client side.
  input  wire logic                              dual_mode_en,
  input  wire logic                              client_sda_out,
  input  wire logic                              client_sda_oe,
  input  wire logic                              client_scl_out,
  input  wire logic                              client_scl_oe,
  output logic                                   client_sda_in,
  output logic                                   client_scl_in,
  // Timer and analog outputs.
  input  wire logic [5:0]                        wave_timer_a0_out,
  input  wire logic [5:0]                        wave_timer_a1_out,
  input  wire logic [4:0]                        single_timer_b_out,
  input  wire logic [3:0]                        quad_timer_d0_out,
  input  wire logic [2:0]                        comparator_out,
  input  wire logic [2:0]                        zero_cross_out,
  // Port pins A..G, eight per port, pin n of port p at p*8+n.
  input  wire logic [pin_route_pkg::NUM_PINS-1:0] pin_in,
  output logic      [pin_route_pkg::NUM_PINS-1:0] pin_out,
  output logic      [pin_route_pkg::NUM_PINS-1:0] pin_oe
);
  import pin_route_pkg::*;

  // Routing registers and their next values.
  logic [TWI_W-1:0]   twi_route_r, twi_route_nxt;     // Two-wire field.
  logic [2*TA_W-1:0]  ta_route_r, ta_route_nxt;       // Timer A fields.
  logic [TB_W-1:0]    tb_route_r, tb_route_nxt;       // Timer B bits.
  logic [TD_W-1:0]    td_route_r, td_route_nxt;       // Timer D field.
  logic [CMP_W-1:0]   cmp_route_r, cmp_route_nxt;     // Comparator bits.
  logic [ZC_W-1:0]    zc_route_r, zc_route_nxt;       // Zero-cross bits.
  // Bus data-phase bookkeeping.
  logic               wr_phase_r, wr_phase_nxt;       // Write pending.
  logic               rd_phase_r, rd_phase_nxt;       // Read in data phase.
  logic [IDX_W-1:0]   idx_r, idx_nxt;                 // Latched index.
  logic [31:0]        hrdata_r, hrdata_nxt;           // Read data flop.
  logic               take;                           // Address accepted.
  // Pin-side values.
  logic [NUM_PINS-1:0] pin_sync;                      // Synchronised pins.
  logic [NUM_PINS-1:0] out_nxt, oe_nxt;               // Next pin drive.
  logic [3:0]          twi_in_nxt, twi_in_r;          // Two-wire inputs.
  logic [2:0]          ta0_sel, ta1_sel;              // Timer A fields.

  assign take      = hsel && htrans[1] && hready;
  assign hreadyout = 1'b1;   // Zero wait states on every access.
  assign hresp     = 1'b0;   // Always OKAY.
  assign hrdata    = hrdata_r;
  assign ta0_sel   = ta_route_r[TA0_LSB +: TA_W];
  assign ta1_sel   = ta_route_r[TA1_LSB +: TA_W];

  // Pins are asynchronous to this clock, so they pass two flops first.
  sync_2ff #(
    .W (NUM_PINS)
  ) u_pin_sync (
    .clk   (clk),
    .rst_n (rst_n),
    .d     (pin_in),
    .q     (pin_sync)
  );

  // Bus phase tracking and register writes in the data phase.
  always_comb
  begin
    wr_phase_nxt  = take && hwrite;
    rd_phase_nxt  = take && !hwrite;
    idx_nxt       = take ? haddr[ADDR_W-1:2] : idx_r;
    twi_route_nxt = twi_route_r;
    ta_route_nxt  = ta_route_r;
    tb_route_nxt  = tb_route_r;
    td_route_nxt  = td_route_r;
    cmp_route_nxt = cmp_route_r;
    zc_route_nxt  = zc_route_r;
    // Only the defined field bits are stored; the rest are dropped.
    if (wr_phase_r)
    begin
      unique case (idx_r)
        IDX_TWO_WIRE: twi_route_nxt = hwdata[TWI_W-1:0];
        IDX_TIMER_A:  ta_route_nxt  = hwdata[2*TA_W-1:0];
        IDX_TIMER_B:  tb_route_nxt  = hwdata[TB_W-1:0];
        IDX_TIMER_D:  td_route_nxt  = hwdata[TD_W-1:0];
        IDX_COMP:     cmp_route_nxt = hwdata[CMP_W-1:0];
        IDX_ZERO_X:   zc_route_nxt  = hwdata[ZC_W-1:0];
        default:      twi_route_nxt = twi_route_r;
      endcase
    end
    // Read data comes from next values so a read right after a write
    // sees the new contents; unmapped addresses read zero.
    hrdata_nxt = hrdata_r;
    if (rd_phase_nxt)
    begin
      unique case (haddr[ADDR_W-1:2])
        IDX_TWO_WIRE: hrdata_nxt = {30'h0, twi_route_nxt};
        IDX_TIMER_A:  hrdata_nxt = {26'h0, ta_route_nxt};
        IDX_TIMER_B:  hrdata_nxt = {27'h0, tb_route_nxt};
        IDX_TIMER_D:  hrdata_nxt = {29'h0, td_route_nxt};
        IDX_COMP:     hrdata_nxt = {29'h0, cmp_route_nxt};
        IDX_ZERO_X:   hrdata_nxt = {29'h0, zc_route_nxt};
        default:      hrdata_nxt = 32'h00000000;
      endcase
    end
  end

  // Register state; every routing field starts at its default pins.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      twi_route_r <= RST_ROUTE[TWI_W-1:0];
      ta_route_r  <= RST_ROUTE[2*TA_W-1:0];
      tb_route_r  <= RST_ROUTE[TB_W-1:0];
      td_route_r  <= RST_ROUTE[TD_W-1:0];
      cmp_route_r <= RST_ROUTE[CMP_W-1:0];
      zc_route_r  <= RST_ROUTE[ZC_W-1:0];
      wr_phase_r  <= 1'b0;
      rd_phase_r  <= 1'b0;
      idx_r       <= '0;
      hrdata_r    <= 32'h00000000;
    end
    else
    begin
      twi_route_r <= twi_route_nxt;
      ta_route_r  <= ta_route_nxt;
      tb_route_r  <= tb_route_nxt;
      td_route_r  <= td_route_nxt;
      cmp_route_r <= cmp_route_nxt;
      zc_route_r  <= zc_route_nxt;
      wr_phase_r  <= wr_phase_nxt;
      rd_phase_r  <= rd_phase_nxt;
      idx_r       <= idx_nxt;
      hrdata_r    <= hrdata_nxt;
    end
  end

  // Pin mux. Sources are applied from lowest to highest priority, so a
  // later source claiming the same pin overrides an earlier one.
  always_comb
  begin
    int hs_sda;
    int hs_scl;
    int cl_sda;
    int cl_scl;
    hs_sda  = -1;
    hs_scl  = -1;
    cl_sda  = -1;
    cl_scl  = -1;
    out_nxt = '0;
    oe_nxt  = '0;
    // Zero-cross outputs: A7 by default, C7 when the bit is set.
    for (int i = 0; i < ZC_W; i++)
    begin
      out_nxt[zc_route_r[i] ? pin_idx(PORT_C, 7) : pin_idx(PORT_A, 7)]
        = zero_cross_out[i];
      oe_nxt[zc_route_r[i] ? pin_idx(PORT_C, 7) : pin_idx(PORT_A, 7)]
        = 1'b1;
    end
    // Comparator outputs: A7 by default, C6 when the bit is set.
    for (int i = 0; i < CMP_W; i++)
    begin
      out_nxt[cmp_route_r[i] ? pin_idx(PORT_C, 6) : pin_idx(PORT_A, 7)]
        = comparator_out[i];
      oe_nxt[cmp_route_r[i] ? pin_idx(PORT_C, 6) : pin_idx(PORT_A, 7)]
        = 1'b1;
    end
    // Single-output timers: one bit picks default or alternate pin.
    for (int i = 0; i < TB_W; i++)
    begin
      out_nxt[tb_route_r[i] ? TB_ALT_PIN[i] : TB_DEF_PIN[i]]
        = single_timer_b_out[i];
      oe_nxt[tb_route_r[i] ? TB_ALT_PIN[i] : TB_DEF_PIN[i]]
        = 1'b1;
    end
    // Timer A1: full six outputs on B and G, three on C and E.
    for (int i = 0; i < 6; i++)
    begin
      unique case (ta1_sel)
        3'h0:
        begin
          out_nxt[pin_idx(PORT_B, i)] = wave_timer_a1_out[i];
          oe_nxt[pin_idx(PORT_B, i)]  = 1'b1;
        end
        3'h1, 3'h2:
        begin
          if (i < 3)
          begin
            out_nxt[pin_idx(ta1_sel[1] ? PORT_E : PORT_C, i + 4)]
              = wave_timer_a1_out[i];
            oe_nxt[pin_idx(ta1_sel[1] ? PORT_E : PORT_C, i + 4)] = 1'b1;
          end
        end
        TA1_PORT_G:
        begin
          out_nxt[pin_idx(PORT_G, i)] = wave_timer_a1_out[i];
          oe_nxt[pin_idx(PORT_G, i)]  = 1'b1;
        end
        default: oe_nxt[0] = oe_nxt[0];  // Reserved: not connected.
      endcase
      // Timer A0: value is the port number; the top code is reserved.
      if (ta0_sel != TA0_RSVD)
      begin
        out_nxt[pin_idx(int'(ta0_sel), i)] = wave_timer_a0_out[i];
        oe_nxt[pin_idx(int'(ta0_sel), i)]  = 1'b1;
      end
    end
    // Timer D: four outputs on a nibble of one port.
    for (int i = 0; i < 4; i++)
    begin
      unique case (td_route_r)
        3'h0:
        begin
          out_nxt[pin_idx(PORT_A, i + 4)] = quad_timer_d0_out[i];
          oe_nxt[pin_idx(PORT_A, i + 4)]  = 1'b1;
        end
        3'h1:
        begin
          out_nxt[pin_idx(PORT_B, i + 4)] = quad_timer_d0_out[i];
          oe_nxt[pin_idx(PORT_B, i + 4)]  = 1'b1;
        end
        3'h2:
        begin
          out_nxt[pin_idx(PORT_F, i)] = quad_timer_d0_out[i];
          oe_nxt[pin_idx(PORT_F, i)]  = 1'b1;
        end
        TD_ALT_THREE:
        begin
          out_nxt[pin_idx(PORT_G, i + 4)] = quad_timer_d0_out[i];
          oe_nxt[pin_idx(PORT_G, i + 4)]  = 1'b1;
        end
        default: oe_nxt[0] = oe_nxt[0];  // Reserved: not connected.
      endcase
    end
    // Two-wire pins; the pairs are open drain, so the peripheral's own
    // enables pass straight through.
    if (twi_route_r == TWI_ALT_TWO)
    begin
      hs_sda = pin_idx(PORT_C, 2);
      hs_scl = pin_idx(PORT_C, 3);
    end
    else if (twi_route_r != TWI_RSVD)
    begin
      hs_sda = pin_idx(PORT_A, 2);
      hs_scl = pin_idx(PORT_A, 3);
    end
    // The client pair exists only in dual mode; C6/C7 suit normal and
    // fast speed only, which is the user's concern.
    if (dual_mode_en && twi_route_r == 2'h0)
    begin
      cl_sda = pin_idx(PORT_C, 2);
      cl_scl = pin_idx(PORT_C, 3);
    end
    else if (dual_mode_en && twi_route_r != TWI_RSVD)
    begin
      cl_sda = pin_idx(PORT_C, 6);
      cl_scl = pin_idx(PORT_C, 7);
    end
    if (cl_sda >= 0)
    begin
      out_nxt[cl_sda] = client_sda_out;
      oe_nxt[cl_sda]  = client_sda_oe;
      out_nxt[cl_scl] = client_scl_out;
      oe_nxt[cl_scl]  = client_scl_oe;
    end
    if (hs_sda >= 0)
    begin
      out_nxt[hs_sda] = host_sda_out;
      oe_nxt[hs_sda]  = host_sda_oe;
      out_nxt[hs_scl] = host_scl_out;
      oe_nxt[hs_scl]  = host_scl_oe;
    end
    // A disconnected two-wire input reads as the idle high level.
    twi_in_nxt[0] = (hs_sda >= 0) ? pin_sync[hs_sda] : 1'b1;
    twi_in_nxt[1] = (hs_scl >= 0) ? pin_sync[hs_scl] : 1'b1;
    twi_in_nxt[2] = (cl_sda >= 0) ? pin_sync[cl_sda] : 1'b1;
    twi_in_nxt[3] = (cl_scl >= 0) ? pin_sync[cl_scl] : 1'b1;
  end

  // Pin drive and two-wire inputs come from flops.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      pin_out  <= '0;
      pin_oe   <= '0;
      twi_in_r <= 4'hF;
    end
    else
    begin
      pin_out  <= out_nxt;
      pin_oe   <= oe_nxt;
      twi_in_r <= twi_in_nxt;
    end
  end

  assign host_sda_in   = twi_in_r[0];
  assign host_scl_in   = twi_in_r[1];
  assign client_sda_in = twi_in_r[2];
  assign client_scl_in = twi_in_r[3];

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  twi_host_alt_a: assert property (
    twi_route_r == 2'h2 |=> pin_oe[18] == $past(host_sda_oe)
      && pin_out[19] == $past(host_scl_out))
    else $error("host pair not on C2/C3");
  twi_rsvd_idle_a: assert property (
    twi_route_r == 2'h3 ##1 twi_route_r == 2'h3 |=> host_sda_in
      && host_scl_in)
    else $error("reserved two-wire code not idle");
  twi_dual_alt_a: assert property (
    dual_mode_en && twi_route_r == 2'h1 |=>
      pin_oe[23] == $past(client_scl_oe)
      && pin_out[22] == $past(client_sda_out))
    else $error("client pair not on C6/C7");
  ta1_port_g_a: assert property (
    ta1_sel == 3'h3 && ta0_sel != 3'h6 |=>
      pin_out[48] == $past(wave_timer_a1_out[0]) && pin_oe[53])
    else $error("timer A1 not on port G");
  ta0_port_e_a: assert property (
    ta0_sel == 3'h4 |=> pin_out[37] == $past(wave_timer_a0_out[5])
      && pin_oe[37])
    else $error("timer A0 not on port E");
  tb_alt_pin_a: assert property (
    tb_route_r[3] && ta0_sel != 3'h2 |=>
      pin_out[17] == $past(single_timer_b_out[3]) && pin_oe[17])
    else $error("timer B3 not on C1");
  tb_def_pin_a: assert property (
    !tb_route_r[2] && ta0_sel != 3'h2 |=>
      pin_out[16] == $past(single_timer_b_out[2]) && pin_oe[16])
    else $error("timer B2 not on C0");
  td_port_f_a: assert property (
    td_route_r == 3'h2 |=> pin_out[43] == $past(quad_timer_d0_out[3])
      && pin_oe[40])
    else $error("timer D not on port F");
  cmp_alt_pin_a: assert property (
    cmp_route_r == 3'h1 && !tb_route_r[4] && !dual_mode_en
      && ta1_sel != 3'h1 |=> pin_out[22] == $past(comparator_out[0]))
    else $error("comparator 0 not on C6");
  zc_alt_pin_a: assert property (
    zc_route_r == 3'h4 && !dual_mode_en |=>
      pin_out[23] == $past(zero_cross_out[2]) && pin_oe[23])
    else $error("zero-cross 2 not on C7");
  route_hold_a: assert property (
    !wr_phase_r |=> $stable(ta_route_r) && $stable(tb_route_r)
      && $stable(zc_route_r))
    else $error("routing changed without a write");
  unused_zero_a: assert property (
    rd_phase_r && idx_r == 6'h07 |-> hrdata[31:5] == 27'h0)
    else $error("unused timer B bits read nonzero");
endmodule : peripheral_pin_routing
`default_nettype wire

//--- pin_peer_model.sv
// Far-side model: peripheral outputs and port pins with pull-ups.
`default_nettype none
module pin_peer_model (
  // Clock.
  input  wire logic                               clk,
  // Peripheral levels to present and pins that an outside party pulls low.
  input  wire logic [26:0]                        src,
  input  wire logic [pin_route_pkg::NUM_PINS-1:0] pull_low,
  // Pin drive coming from the routing block.
  input  wire logic [pin_route_pkg::NUM_PINS-1:0] pin_out,
  input  wire logic [pin_route_pkg::NUM_PINS-1:0] pin_oe,
  // Peripheral outputs towards the routing block.
  output var  logic [5:0]                         wave_timer_a0_out,
  output var  logic [5:0]                         wave_timer_a1_out,
  output var  logic [4:0]                         single_timer_b_out,
  output var  logic [3:0]                         quad_timer_d0_out,
  output var  logic [2:0]                         comparator_out,
  output var  logic [2:0]                         zero_cross_out,
  // Resolved pin levels.
  output logic      [pin_route_pkg::NUM_PINS-1:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ns;
  import pin_route_pkg::*;

  // Peripherals follow the command just after each edge; reset is held
  // long enough that their unknown start never reaches a pin flop.
  always @(posedge clk)
  begin
    {zero_cross_out, comparator_out, quad_timer_d0_out, single_timer_b_out,
     wave_timer_a1_out, wave_timer_a0_out} <= src;
  end

  // An undriven pin floats to its pull-up unless someone outside pulls it.
  always_comb
  begin
    for (int i = 0; i < NUM_PINS; i++)
      pin_in[i] = pin_oe[i] ? pin_out[i] : ~pull_low[i];
  end
endmodule : pin_peer_model
`default_nettype wire

//--- testbench.sv
// Self-checking testbench for the peripheral pin routing block.
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ns;
  import pin_route_pkg::*;
  // Clock, reset and bus signals.
  logic        clk = 1'b0, rst_n = 1'b0, hsel = 1'b0, hwrite = 1'b0;
  logic [7:0]  haddr = 8'h00;
  logic [1:0]  htrans = 2'h0;
  logic [2:0]  hsize = 3'h2;
  logic [31:0] hwdata = 32'h0, hrdata, rd;
  logic        hreadyout, hresp;
  // Two-wire drive and returned levels.
  logic host_sda_out = 1'b1, host_sda_oe = 1'b0, host_sda_in, host_scl_in;
  logic host_scl_out = 1'b1, host_scl_oe = 1'b0, client_sda_in;
  logic client_sda_out = 1'b1, client_sda_oe = 1'b0, client_scl_in;
  logic client_scl_out = 1'b1, client_scl_oe = 1'b0, dual_mode_en = 1'b0;
  // Peripheral outputs, far-side commands and pins.
  logic [5:0]  wave_timer_a0_out, wave_timer_a1_out;
  logic [4:0]  single_timer_b_out;
  logic [3:0]  quad_timer_d0_out;
  logic [2:0]  comparator_out, zero_cross_out;
  logic [26:0] src = {3'b011, 3'b110, 4'h9, 5'h16, 6'h12, 6'h2D};
  logic [55:0] pull_low = 56'h0, pin_in, pin_out, pin_oe;
  int          errors = 0, comparisons = 0;

  always #25 clk = ~clk;

  peripheral_pin_routing peripheral_pin_routing_inst (.clk, .rst_n, .hsel,
    .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata,
    .hreadyout, .hresp, .host_sda_out, .host_sda_oe, .host_scl_out,
    .host_scl_oe, .host_sda_in, .host_scl_in, .dual_mode_en, .client_sda_out,
    .client_sda_oe, .client_scl_out, .client_scl_oe, .client_sda_in,
    .client_scl_in, .wave_timer_a0_out, .wave_timer_a1_out,
    .single_timer_b_out, .quad_timer_d0_out, .comparator_out,
    .zero_cross_out, .pin_in, .pin_out, .pin_oe);
  pin_peer_model pin_peer_model_inst (.clk, .src, .pull_low, .pin_out,
    .pin_oe, .wave_timer_a0_out, .wave_timer_a1_out, .single_timer_b_out,
    .quad_timer_d0_out, .comparator_out, .zero_cross_out, .pin_in);

  // Compares one value and counts the outcome.
  task automatic check(input string what, input logic [31:0] seen, exp);
    comparisons++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  // Prints the counts and the verdict, then ends the run.
  task automatic finish_test;
    $display("errors %0d comparisons %0d", errors, comparisons);
    if (errors == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask : finish_test

  task automatic wt(input int n);
    repeat (n) @(posedge clk);
  endtask : wt

  // One single AHB-Lite transfer; entered just after a rising edge.
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    haddr <= a;
    hwrite <= w;
    htrans <= 2'h2;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : bus

  // Every register and one unmapped word read zero after reset.
  task automatic test_reset_values;
    for (int i = 5; i <= 11; i++)
    begin
      bus(1'b0, 8'(i * 4), 32'h0);
      check("reset value", rd, 32'h0);
    end
  endtask : test_reset_values

  // All-ones writes keep only the defined fields.
  task automatic test_masks;
    logic [31:0] m [7] = '{32'h3, 32'h3F, 32'h1F, 32'h7, 32'h7, 32'h7, 32'h0};
    for (int i = 5; i <= 11; i++)
    begin
      bus(1'b1, 8'(i * 4), 32'hFFFFFFFF);
      bus(1'b0, 8'(i * 4), 32'h0);
      check("field mask", rd, m[i - 5]);
      check("response", hresp, 32'h0);
      bus(1'b1, 8'(i * 4), 32'h0);
    end
  endtask : test_masks

  // Timer A0 steps through ports A to G, then the reserved code.
  task automatic test_a0;
    bus(1'b1, 8'h14, 32'h3);
    bus(1'b1, 8'h20, 32'h4);
    for (int v = 0; v < 8; v++)
    begin
      bus(1'b1, 8'h18, 32'(v));
      wt(3);
      if (v < 7)
      begin
        check("a0 pins", pin_out[v * 8 +: 6], 32'h2D);
        check("a0 enables", pin_oe[v * 8 +: 6], 32'h3F);
      end
      else
        check("a0 reserved", pin_oe[24 +: 6], 32'h0);
    end
  endtask : test_a0

  // Timer A1 on ports B, C, E, G, then a reserved code.
  task automatic test_a1;
    int b [4] = '{8, 20, 36, 48};
    logic [31:0] wm;
    for (int v = 0; v < 5; v++)
    begin
      bus(1'b1, 8'h18, 32'(v * 8 + 3));
      wt(3);
      wm = (v == 1 || v == 2) ? 32'h7 : 32'h3F;
      if (v < 4)
        check("a1 pins", pin_out[b[v] +: 6] & wm, 32'h12 & wm);
      else
        check("a1 reserved", pin_oe[36 +: 3], 32'h0);
    end
  endtask : test_a1

  // Timer D on ports A, B, F, G, then a reserved code.
  task automatic test_d;
    int b [4] = '{4, 12, 40, 52};
    bus(1'b1, 8'h18, 32'h23);
    for (int v = 0; v < 5; v++)
    begin
      bus(1'b1, 8'h20, 32'(v));
      wt(3);
      if (v < 4)
        check("d pins", {pin_oe[b[v] +: 4], pin_out[b[v] +: 4]}, 32'hF9);
      else
        check("d reserved", pin_oe[40 +: 4], 32'h0);
    end
  endtask : test_d

  // Single-output timers on their default pins, then all alternates.
  task automatic test_b;
    int p [2][5] = '{'{2, 3, 16, 13, 51}, '{44, 45, 12, 17, 22}};
    for (int v = 0; v < 2; v++)
    begin
      bus(1'b1, 8'h1C, v ? 32'h1F : 32'h0);
      wt(3);
      for (int i = 0; i < 5; i++)
        check("b pin", {pin_oe[p[v][i]], pin_out[p[v][i]]}, {1'b1, src[12 + i]});
    end
  endtask : test_b

  // Highest-index match among three outputs with a given select value.
  function automatic logic [1:0] pick(input logic [2:0] s, val, input logic w);
    logic [1:0] r;
    r = 2'b00;
    for (int i = 0; i < 3; i++)
      if (s[i] == w)
        r = {1'b1, val[i]};
    return r;
  endfunction : pick

  // Comparator and zero-cross outputs between A7, C6 and C7.
  task automatic test_analog;
    logic [1:0] e;
    bus(1'b1, 8'h1C, 32'h0);
    for (int v = 0; v < 8; v++)
    begin
      bus(1'b1, 8'h24, 32'(v));
      bus(1'b1, 8'h28, 32'(v ^ 6));
      wt(3);
      e = pick(3'(v), 3'b110, 1'b0);
      if (!e[1])
        e = pick(3'(v ^ 6), 3'b011, 1'b0);
      check("a7", {pin_oe[7], pin_oe[7] & pin_out[7]}, {e[1], &e});
      e = pick(3'(v), 3'b110, 1'b1);
      check("c6", {pin_oe[22], pin_oe[22] & pin_out[22]}, {e[1], &e});
      e = pick(3'(v ^ 6), 3'b011, 1'b1);
      check("c7", {pin_oe[23], pin_oe[23] & pin_out[23]}, {e[1], &e});
    end
    bus(1'b1, 8'h24, 32'h0);
    bus(1'b1, 8'h28, 32'h0);
  endtask : test_analog

  // Two-wire pairs: data driven low, clock held low by an outside party.
  task automatic test_two_wire;
    int hp [4] = '{2, 2, 18, 2};
    int cp [4] = '{18, 22, 22, 22};
    {host_sda_out, host_sda_oe, client_sda_out, client_sda_oe} <= 4'b0101;
    dual_mode_en <= 1'b1;
    for (int v = 0; v < 4; v++)
    begin
      pull_low <= (56'h1 << (hp[v] + 1)) | (56'h1 << (cp[v] + 1))
        | (56'h1 << 19);
      bus(1'b1, 8'h14, 32'(v));
      wt(6);
      if (v < 3)
      begin
        check("host pins", {pin_oe[hp[v]], pin_out[hp[v]]}, 32'h2);
        check("client pins", {pin_oe[cp[v]], pin_out[cp[v]]}, 32'h2);
        check("host in", {host_sda_in, host_scl_in}, 32'h0);
        check("client in", {client_sda_in, client_scl_in}, 32'h0);
      end
      else
      begin
        check("host idle", {host_sda_in, host_scl_in}, 32'h3);
        check("client idle", {client_sda_in, client_scl_in}, 32'h3);
        check("reserved oe", {pin_oe[18], pin_oe[22]}, 32'h0);
      end
    end
  endtask : test_two_wire

  // Watchdog against a hung handshake.
  initial
  begin
    wt(20000);
    errors++;
    finish_test();
  end

  // Main sequence.
  initial
  begin
    wt(10);
    rst_n <= 1'b1;
    wt(1);
    test_reset_values();
    test_masks();
    test_a0();
    test_a1();
    test_d();
    test_b();
    test_analog();
    test_two_wire();
    rst_n <= 1'b0;
    wt(2);
    rst_n <= 1'b1;
    wt(1);
    test_reset_values();
    finish_test();
  end
endmodule : testbench
`default_nettype wire
